// ---- design/bbd_defs.vh ----
// Constants for the bitstream burst delivery block
`ifndef BBD_DEFS_VH
`define BBD_DEFS_VH
`define BBD_ADDR_W 23
`define BBD_DATA_W 16
`define BBD_ADDR_ZERO 23'h00_0000
`define BBD_ADDR_ONE 23'h00_0001
`define BBD_DATA_ZERO 16'h0000
`define BBD_DATA_ERASED 16'hffff
`define BBD_MEM_DEPTH_LOG2 10
// Internal ready delay after reset, in cycles
`define BBD_READY_CYCLES 8'h10
`define BBD_CNT_ZERO 8'h00
`define BBD_CNT_ONE 8'h01
// Program/erase busy time, in cycles
`define BBD_PE_CYCLES 8'h20
`endif

// ---- design/bbd_array.v ----
// Storage array with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "bbd_defs.vh"
module bbd_array (
   input wire clk_in,
   input wire rd_en_in,
   input wire [`BBD_MEM_DEPTH_LOG2-1:0] rd_addr_in,
   input wire wr_en_in,
   input wire [`BBD_MEM_DEPTH_LOG2-1:0] wr_addr_in,
   input wire [`BBD_DATA_W-1:0] wr_data_in,
   output reg [`BBD_DATA_W-1:0] rd_data_out
);
   reg [`BBD_DATA_W-1:0] mem [0:(1<<`BBD_MEM_DEPTH_LOG2)-1];
   always @(posedge clk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
      if (rd_en_in) begin
         rd_data_out <= mem[rd_addr_in];
      end
   end
endmodule // bbd_array
`default_nettype wire

// ---- design/bbd_top.v ----
// Flash-side configuration bitstream burst delivery
// Functional notes
// - Low program supply refuses program and erase
// - Program supply sampled only at operation start
// - Hold ready line low during reset
// - Start on released line seen high, edge or level
// - Load start address, present first word
// - Each clock: increment address, next word
// - Single burst mode, sixteen-bit data path
// - One word per clock sustained
// - Wait for valid high before reading
// - Reset enters burst mode, first latch sequence
// - Address captured on clock while latch low
`timescale 1ns/1ps
`default_nettype none
`include "bbd_defs.vh"
module bbd_top (
   input wire clk_in,
   input wire sys_rst_in,
   input wire ready_line_in,
   output wire ready_line_out,
   output wire ready_line_oe_out,
   input wire latch_en_n_in,
   input wire [`BBD_ADDR_W-1:0] addr_in,
   input wire out_en_n_in,
   input wire prog_req_in,
   input wire erase_req_in,
   input wire [`BBD_DATA_W-1:0] prog_data_in,
   input wire prog_supply_ok_in,
   output wire [`BBD_DATA_W-1:0] data_out,
   output wire data_oe_out,
   output reg data_valid_out,
   output reg [`BBD_ADDR_W-1:0] cur_addr_out,
   output reg pe_busy_out,
   output reg pe_refused_out
);
   // -------------------------------------------------------------
   // States
   // -------------------------------------------------------------
   localparam ST_RESET = 4'b0001;
   localparam ST_WAITHI = 4'b0010;
   localparam ST_LATCH = 4'b0100;
   localparam ST_BURST = 4'b1000;

   reg [3:0] state_ff;
   reg [3:0] nxt_state;
   reg [7:0] rdy_cnt_ff;
   reg rl_s1_ff;
   reg rl_s2_ff;
   reg rl_prev_ff;
   reg le_s1_ff;
   reg le_s2_ff;
   reg oe_s1_ff;
   reg oe_s2_ff;
   reg ps_s1_ff;
   reg ps_s2_ff;
   reg [7:0] pe_cnt_ff;
   reg [`BBD_ADDR_W-1:0] pe_addr_ff;
   reg [`BBD_DATA_W-1:0] pe_data_ff;
   reg pe_wr_ff;
   reg [`BBD_ADDR_W-1:0] nxt_addr;
   wire [`BBD_DATA_W-1:0] arr_q;

   function [`BBD_MEM_DEPTH_LOG2-1:0] arr_idx;
      input [`BBD_ADDR_W-1:0] a;
      begin
         arr_idx = a[`BBD_MEM_DEPTH_LOG2-1:0];
      end
   endfunction

   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   // Address and requests share our clock and skip this; the
   // gate array holds the address steady while the latch settles
   always @(posedge clk_in) begin
      rl_s1_ff <= ready_line_in;
      rl_s2_ff <= rl_s1_ff;
      le_s1_ff <= latch_en_n_in;
      le_s2_ff <= le_s1_ff;
      oe_s1_ff <= out_en_n_in;
      oe_s2_ff <= oe_s1_ff;
      ps_s1_ff <= prog_supply_ok_in;
      ps_s2_ff <= ps_s1_ff;
   end

   // Line seen low while we release it means a restart request
   wire line_high = rl_s2_ff;
   wire line_rise = rl_s2_ff & ~rl_prev_ff;
   wire restart = ~rl_s2_ff & rl_prev_ff & (state_ff == ST_BURST);

   // -------------------------------------------------------------
   // Ready handshake and burst sequencing
   // -------------------------------------------------------------
   // Open drain: only ever drive low
   assign ready_line_out = 1'b0;
   assign ready_line_oe_out = (state_ff == ST_RESET);

   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_RESET: begin
            if (rdy_cnt_ff == `BBD_CNT_ZERO) begin
               nxt_state = ST_WAITHI;
            end
         end
         ST_WAITHI: begin
            // Shared line seen high opens the burst, with or without a rising edge
            if (line_rise | line_high) begin
               nxt_state = ST_LATCH;
            end
         end
         ST_LATCH: begin
            // Line pulled low before the latch: wait for it again
            if (~line_high) begin
               nxt_state = ST_WAITHI;
            end else if (~le_s2_ff) begin
               nxt_state = ST_BURST;
            end
         end
         ST_BURST: begin
            if (restart) begin
               nxt_state = ST_WAITHI;
            end
         end
         default: nxt_state = ST_RESET;
      endcase
   end

   always @* begin
      nxt_addr = cur_addr_out;
      if (state_ff == ST_LATCH && line_high && ~le_s2_ff) begin
         nxt_addr = addr_in;
      end else if (state_ff == ST_BURST && data_valid_out) begin
         // Full width wrap, no re-drive of the address needed
         nxt_addr = cur_addr_out + `BBD_ADDR_ONE;
      end
   end

   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_ff <= ST_RESET;
         rdy_cnt_ff <= `BBD_READY_CYCLES;
         rl_prev_ff <= 1'b0;
         cur_addr_out <= `BBD_ADDR_ZERO;
         data_valid_out <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         rl_prev_ff <= rl_s2_ff;
         // Ready delay runs down only while the line is held
         if (state_ff == ST_RESET && rdy_cnt_ff != `BBD_CNT_ZERO) begin
            rdy_cnt_ff <= rdy_cnt_ff - `BBD_CNT_ONE;
         end
         cur_addr_out <= nxt_addr;
         // One word per clock once the burst runs
         data_valid_out <= (nxt_state == ST_BURST);
      end
   end

   // -------------------------------------------------------------
   // Program and erase gate
   // -------------------------------------------------------------
   wire pe_start = (prog_req_in | erase_req_in) & ~pe_busy_out & (state_ff == ST_BURST
      | state_ff == ST_LATCH);

   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         pe_busy_out <= 1'b0;
         pe_refused_out <= 1'b0;
         pe_cnt_ff <= `BBD_CNT_ZERO;
         pe_addr_ff <= `BBD_ADDR_ZERO;
         pe_data_ff <= `BBD_DATA_ZERO;
         pe_wr_ff <= 1'b0;
      end else begin
         pe_wr_ff <= 1'b0;
         if (pe_start) begin
            // Supply level looked at only here
            if (ps_s2_ff) begin
               pe_busy_out <= 1'b1;
               pe_refused_out <= 1'b0;
               pe_cnt_ff <= `BBD_PE_CYCLES;
               pe_addr_ff <= addr_in;
               pe_data_ff <= erase_req_in ? `BBD_DATA_ERASED : prog_data_in;
            end else begin
               pe_refused_out <= 1'b1;
            end
         end else if (pe_busy_out) begin
            // Running operation ignores supply changes
            if (pe_cnt_ff == `BBD_CNT_ONE) begin
               pe_busy_out <= 1'b0;
               pe_wr_ff <= 1'b1;
            end
            pe_cnt_ff <= pe_cnt_ff - `BBD_CNT_ONE;
         end
      end
   end

   // -------------------------------------------------------------
   // Array and data outputs
   // -------------------------------------------------------------
   bbd_array u_array (
      .clk_in(clk_in),
      .rd_en_in(nxt_state == ST_BURST),
      .rd_addr_in(arr_idx(nxt_addr)),
      .wr_en_in(pe_wr_ff),
      .wr_addr_in(arr_idx(pe_addr_ff)),
      .wr_data_in(pe_data_ff),
      .rd_data_out(arr_q)
   );

   assign data_out = arr_q;
   assign data_oe_out = data_valid_out & ~oe_s2_ff;
endmodule // bbd_top
`default_nettype wire

// ---- bench/bbd_top_asserts.sv ----
// Port-level checker for the burst delivery block
`timescale 1ns/1ps
`default_nettype none
`include "bbd_defs.vh"
module bbd_top_asserts (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic ready_line_in,
   input wire logic ready_line_oe_out,
   input wire logic [`BBD_ADDR_W-1:0] addr_in,
   input wire logic prog_req_in,
   input wire logic erase_req_in,
   input wire logic prog_supply_ok_in,
   input wire logic data_valid_out,
   input wire logic [`BBD_ADDR_W-1:0] cur_addr_out,
   input wire logic pe_busy_out,
   input wire logic pe_refused_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   a_oe_in_reset: assert property (disable iff (1'b0) sys_rst_in |=> ready_line_oe_out)
      else $error("ready line not held low in reset");
   a_release_oe_late: assert property ($fell(sys_rst_in) |->
      ready_line_oe_out [*8] ##[4:12] !ready_line_oe_out)
      else $error("ready line release timing wrong");
   a_no_burst_held: assert property (ready_line_oe_out |-> !data_valid_out)
      else $error("burst while ready line held");
   a_start_addr_load: assert property ($rose(data_valid_out) |->
      cur_addr_out == $past(addr_in))
      else $error("first word address not the latched one");
   a_addr_step_one: assert property (data_valid_out && $past(data_valid_out) |->
      cur_addr_out == $past(cur_addr_out) + 23'h00_0001)
      else $error("address did not advance by one");
   a_line_low_restart: assert property (!ready_line_in [*6] |-> !data_valid_out)
      else $error("burst kept running with line low");
   a_refuse_low_supply: assert property ((prog_req_in || erase_req_in) && !pe_busy_out
      && !prog_supply_ok_in && !$past(prog_supply_ok_in, 3)
      |-> ##[1:3] pe_refused_out && !pe_busy_out)
      else $error("operation not refused at low supply");
   a_busy_runs_out: assert property ($rose(pe_busy_out) |->
      pe_busy_out [*8] ##[20:30] !pe_busy_out)
      else $error("operation length wrong");
   c_burst: cover property ($rose(data_valid_out));
   c_refused: cover property ($rose(pe_refused_out));
   c_op_done: cover property ($fell(pe_busy_out));
endmodule // bbd_top_asserts
bind bbd_top bbd_top_asserts u_chk (.clk_in, .sys_rst_in, .ready_line_in, .ready_line_oe_out,
   .addr_in, .prog_req_in, .erase_req_in, .prog_supply_ok_in, .data_valid_out, .cur_addr_out,
   .pe_busy_out, .pe_refused_out);
`default_nettype wire

// ---- bench/bbd_gate_model.sv ----
// Behavioural gate array configuration port
`timescale 1ns/1ps
`default_nettype none
module bbd_gate_model (
   input wire logic clk_in,
   input wire logic hold_in,
   input wire logic arm_in,
   input wire logic line_in,
   input wire logic [22:0] start_in,
   input wire logic word_valid_in,
   output logic init_oe_out,
   output logic latch_en_n_out,
   output logic [22:0] addr_out,
   output logic done_out
);
   int lcnt = 0;
   int wcnt = 0;
   logic line_d = 1'b0;
   assign init_oe_out = hold_in; // Held low while clearing
   assign addr_out = start_in; // Master drives the read address
   assign latch_en_n_out = !(lcnt > 0);
   // Starts its design once two words came in; no fallback retry
   assign done_out = (wcnt == 2);
   always @(posedge clk_in) begin
      line_d <= line_in;
      // Latch only on the low-to-high edge of the shared line
      if (arm_in && line_in && !line_d)
         lcnt <= 3;
      else if (lcnt > 0)
         lcnt <= lcnt - 1;
      // A new clear of the gate array drops done
      if (hold_in)
         wcnt <= 0;
      else if (word_valid_in && wcnt < 2)
         wcnt <= wcnt + 1;
   end
endmodule // bbd_gate_model
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking testbench for the burst delivery block
`timescale 1ns/1ps
`default_nettype none
`include "bbd_defs.vh"
module tb;
   logic clk_in = 0, sys_rst_in = 1, preq = 0, ereq = 0, ok = 1, hold = 0, arm = 0;
   logic [15:0] pdata = 16'h0000;
   logic [22:0] start = 23'h00_0000;
   wire line, ga_oe, dut_oe, lat_n, dv, busy, refd, dut_lvl, doe, done;
   wire [15:0] dout;
   wire [22:0] ga_addr, cur;
   int fails = 0, comparisons = 0, cyc = 0;
   assign line = !ga_oe && !(dut_oe && !dut_lvl); // Pull-up only wins when both release
   bbd_gate_model u_ga (.clk_in(clk_in), .hold_in(hold), .arm_in(arm), .line_in(line),
      .start_in(start), .word_valid_in(dv), .init_oe_out(ga_oe), .latch_en_n_out(lat_n),
      .addr_out(ga_addr), .done_out(done));
   bbd_top dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ready_line_in(line),
      .ready_line_out(dut_lvl), .ready_line_oe_out(dut_oe), .latch_en_n_in(lat_n),
      .addr_in(ga_addr), .out_en_n_in(1'b0), .prog_req_in(preq), .erase_req_in(ereq),
      .prog_data_in(pdata), .prog_supply_ok_in(ok), .data_out(dout), .data_oe_out(doe),
      .data_valid_out(dv), .cur_addr_out(cur), .pe_busy_out(busy), .pe_refused_out(refd));
   initial begin
      forever #50 clk_in = ~clk_in; // Steady clock, well under the burst limit
   end
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         results;
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic chk(input logic [22:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic pe(input logic er, input logic [22:0] a, input logic [15:0] d);
      start = a;
      pdata = d;
      preq = !er;
      ereq = er;
      step(1);
      preq = 0;
      ereq = 0;
   endtask
   // Restart via the shared line, then judge the first two words
   task automatic rd(input logic [22:0] a, input logic [15:0] d0, d1);
      int n = 0;
      start = a;
      arm = 1;
      hold = 1;
      step(8);
      hold = 0;
      while (dv !== 1'b1 && n < 100) begin
         step(1);
         n++;
      end
      chk(cur, a);
      chk(dout, d0);
      chk(doe, 1'b1);
      step(1);
      chk(cur, a + 23'h00_0001);
      chk(dout, d1);
      step(1);
      chk(done, 1'b1);
      arm = 0;
      hold = 1;
      step(8);
      hold = 0;
      step(24);
   endtask
   task automatic test_program;
      pe(0, 23'h7f_ffff, 16'h1234);
      step(40);
      pe(0, 23'h00_0000, 16'h5678);
      step(40);
      rd(23'h7f_ffff, 16'h1234, 16'h5678);
      $display("test_program done");
   endtask
   task automatic test_erase_refuse;
      pe(1, 23'h00_0000, 16'h0000);
      step(4);
      ok = 0;
      step(40);
      pe(0, 23'h00_0000, 16'habcd);
      step(4);
      chk(refd, 1'b1);
      chk(busy, 1'b0);
      ok = 1;
      step(4);
      rd(23'h7f_ffff, 16'h1234, 16'hffff);
      $display("test_erase_refuse done");
   endtask
   // Reset in mid-run: line held through the ready delay, then a new burst
   task automatic test_reset;
      sys_rst_in = 1;
      step(3);
      chk(dut_oe, 1'b1);
      chk(line, 1'b0);
      chk(dv, 1'b0);
      sys_rst_in = 0;
      step(`BBD_READY_CYCLES);
      chk(dut_oe, 1'b1);
      step(2);
      chk(dut_oe, 1'b0);
      step(8);
      rd(23'h7f_ffff, 16'h1234, 16'hffff);
      $display("test_reset done");
   endtask
   task automatic results;
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      step(3);
      sys_rst_in = 0;
      step(30);
      test_program;
      test_erase_refuse;
      test_reset;
      results;
   end
endmodule // tb
`default_nettype wire
